// ---- sdb_mem_model.sv ----
`timescale 1ns/10ps
module sdb_mem_model #(
	parameter int AW = 5,
	parameter int DW = 8
) (
	input  wire logic          clk_i,   // clock
	input  wire logic          en_i,    // shared clock enable
	input  wire logic          req_i,   // access strobe
	input  wire logic          we_i,    // write
	input  wire logic [AW-1:0] addr_i,  // address
	input  wire logic [DW-1:0] wdata_i, // write data
	input  wire logic          flip_i,  // corrupt reads
	output logic      [DW-1:0] rdata_o  // read data
);
	logic [DW-1:0] mem [2**AW];
	initial rdata_o = '0;
	// data is valid one cycle only, then toggles so stale reads show
	always @(posedge clk_i)
	begin
		if (en_i && req_i && we_i)
			mem[addr_i] <= wdata_i;
		if (en_i && req_i && !we_i)
			rdata_o <= mem[addr_i] ^ {DW{flip_i}};
		else if (en_i)
			rdata_o <= ~rdata_o;
	end
endmodule : sdb_mem_model

// ---- sdb_pkg.sv ----
package sdb_pkg;

	// default geometry of the memory under test
	localparam int BANK_W_DEF = 2;
	localparam int ROW_W_DEF  = 4;
	localparam int COL_W_DEF  = 4;
	localparam int DATA_W_DEF = 8;

	// disturb repeat counter: width and end count loaded at start
	localparam int         CNT_W   = 2;
	localparam logic [1:0] CNT_END = 2'h1;
	localparam logic [1:0] CNT_RST = 2'h0;

	// inner variation loop: pass 0 plain, 1..3 are the replays
	localparam logic [1:0] INNER_RST  = 2'h0;
	localparam logic [1:0] INNER_LAST = 2'h3;
	localparam int         INNER_REV  = 0;
	localparam int         INNER_INV  = 1;

	// outer inversion loop: pass 0 plain, pass 1 inverted
	localparam logic OUTER_RST  = 1'b0;
	localparam logic OUTER_LAST = 1'b1;

	// base data pattern is an all-zero word
	localparam logic BASE_BIT = 1'b0;

	typedef enum logic [3:0] {
		SDB_IDLE  = 4'h0,
		SDB_BKGND = 4'h1,
		SDB_OFFS  = 4'h2,
		SDB_WCOL  = 4'h3,
		SDB_RDCOL = 4'h4,
		SDB_WROW  = 4'h5,
		SDB_RDROW = 4'h6,
		SDB_MOVE  = 4'h7,
		SDB_BANK  = 4'h8,
		SDB_DONE  = 4'h9
	} sdb_state_t;

endpackage : sdb_pkg

// ---- sdb_surround_disturb_bist.sv ----
`timescale 1ns/10ps

module sdb_surround_disturb_bist #(
	parameter int BANK_W = sdb_pkg::BANK_W_DEF,
	parameter int ROW_W  = sdb_pkg::ROW_W_DEF,
	parameter int COL_W  = sdb_pkg::COL_W_DEF,
	parameter int DATA_W = sdb_pkg::DATA_W_DEF
) (
	input  wire logic                            clk_i,       // 250 MHz clock
	input  wire logic                            rst_i,       // async reset, high
	input  wire logic                            en_i,        // clock enable
	input  wire logic                            start_i,     // start pulse
	input  wire logic [DATA_W-1:0]               mem_rdata_i, // read data
	output logic                                 mem_en_o,    // access strobe
	output logic                                 mem_we_o,    // write when high
	output logic [BANK_W+ROW_W+COL_W-1:0]        mem_addr_o,  // {bank,col,row}
	output logic [DATA_W-1:0]                    mem_wdata_o, // write data
	output logic                                 busy_o,      // test running
	output logic                                 done_o,      // test finished
	output logic                                 fail_o       // sticky mismatch
);

	sdb_pkg::sdb_state_t state_q;
	sdb_pkg::sdb_state_t state_d;

	logic [BANK_W-1:0]          home_bank_q;
	logic [ROW_W-1:0]           home_row_q;
	logic [COL_W-1:0]           home_col_q;
	logic [BANK_W-1:0]          nb_bank_q;
	logic [ROW_W-1:0]           nb_row_q;
	logic [COL_W-1:0]           nb_col_q;
	logic [sdb_pkg::CNT_W-1:0]  cnt_q;
	logic [sdb_pkg::CNT_W-1:0]  cnt_end_q;
	logic [1:0]                 inner_q;
	logic                       outer_q;
	logic [DATA_W-1:0]          data_q;
	logic [DATA_W-1:0]          exp_q;
	logic                       chk_q;
	logic [DATA_W-1:0]          chk_exp_q;

	logic                       go;
	logic                       row_last;
	logic                       col_last;
	logic                       rc_last;
	logic                       bank_last;
	logic                       cnt_end;
	logic                       inner_last;
	logic                       rev;
	logic                       winv;
	logic [ROW_W-1:0]           home_row_inc;
	logic [COL_W-1:0]           home_col_inc;
	logic [BANK_W-1:0]          home_bank_inc;
	logic [DATA_W-1:0]          outer_mask;
	logic [DATA_W-1:0]          winv_mask;

	assign go            = start_i && (state_q == sdb_pkg::SDB_IDLE
		|| state_q == sdb_pkg::SDB_DONE);
	assign row_last      = &home_row_q;
	assign col_last      = &home_col_q;
	assign rc_last       = row_last && col_last;
	assign bank_last     = &home_bank_q;
	assign cnt_end       = (cnt_q == cnt_end_q);
	assign inner_last    = (inner_q == sdb_pkg::INNER_LAST);
	assign rev           = inner_q[sdb_pkg::INNER_REV];
	assign winv          = inner_q[sdb_pkg::INNER_INV];
	// rows count fastest; column moves only on the row carry
	assign home_row_inc  = home_row_q + ROW_W'(1);
	assign home_col_inc  = row_last ? home_col_q + COL_W'(1)
		: home_col_q;
	assign home_bank_inc = home_bank_q + BANK_W'(1);
	assign outer_mask    = {DATA_W{outer_q}};
	assign winv_mask     = {DATA_W{winv}};

	always_comb
	begin
		state_d = state_q;
		case (state_q)
			sdb_pkg::SDB_IDLE,
			sdb_pkg::SDB_DONE:
			begin
				if (start_i)
					state_d = sdb_pkg::SDB_BKGND;
			end
			sdb_pkg::SDB_BKGND:
			begin
				if (rc_last)
					state_d = sdb_pkg::SDB_OFFS;
			end
			sdb_pkg::SDB_OFFS:
				state_d = sdb_pkg::SDB_WCOL;
			sdb_pkg::SDB_WCOL:
				state_d = sdb_pkg::SDB_RDCOL;
			sdb_pkg::SDB_RDCOL:
			begin
				state_d = cnt_end ? sdb_pkg::SDB_WROW
					: sdb_pkg::SDB_WCOL;
			end
			sdb_pkg::SDB_WROW:
				state_d = sdb_pkg::SDB_RDROW;
			sdb_pkg::SDB_RDROW:
			begin
				if (!cnt_end)
					state_d = sdb_pkg::SDB_WROW;
				else if (inner_last)
					state_d = sdb_pkg::SDB_MOVE;
				else
					state_d = sdb_pkg::SDB_WCOL;
			end
			sdb_pkg::SDB_MOVE:
			begin
				state_d = rc_last ? sdb_pkg::SDB_BANK
					: sdb_pkg::SDB_OFFS;
			end
			sdb_pkg::SDB_BANK:
			begin
				if (bank_last && outer_q == sdb_pkg::OUTER_LAST)
					state_d = sdb_pkg::SDB_DONE;
				else
					state_d = sdb_pkg::SDB_BKGND;
			end
			default:
				state_d = sdb_pkg::SDB_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			state_q <= sdb_pkg::SDB_IDLE;
		else if (en_i)
			state_q <= state_d;
	end

	// home cell address; wraps to zero after its last value
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			home_bank_q <= '0;
			home_row_q  <= '0;
			home_col_q  <= '0;
		end
		else if (en_i)
		begin
			if (go)
			begin
				home_bank_q <= '0;
				home_row_q  <= '0;
				home_col_q  <= '0;
			end
			else if (state_q == sdb_pkg::SDB_BKGND
				|| state_q == sdb_pkg::SDB_MOVE)
			begin
				home_row_q <= home_row_inc;
				home_col_q <= home_col_inc;
			end
			else if (state_q == sdb_pkg::SDB_BANK)
				home_bank_q <= home_bank_inc;
		end
	end

	// neighbour address; row and column count on their own, bank is only loaded
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			nb_bank_q <= '0;
			nb_row_q  <= '0;
			nb_col_q  <= '0;
		end
		else if (en_i)
		begin
			case (state_q)
				sdb_pkg::SDB_IDLE,
				sdb_pkg::SDB_DONE:
				begin
					if (start_i)
					begin
						nb_bank_q <= '0;
						nb_row_q  <= '0;
						nb_col_q  <= '0;
					end
				end
				sdb_pkg::SDB_OFFS:
				begin
					nb_row_q <= nb_row_q - ROW_W'(1);
					nb_col_q <= nb_col_q - COL_W'(1);
				end
				sdb_pkg::SDB_WCOL:
				begin
					if (rev)
						nb_col_q <= nb_col_q - COL_W'(1);
					else
						nb_col_q <= nb_col_q + COL_W'(1);
				end
				sdb_pkg::SDB_WROW:
				begin
					if (rev)
						nb_row_q <= nb_row_q - ROW_W'(1);
					else
						nb_row_q <= nb_row_q + ROW_W'(1);
				end
				sdb_pkg::SDB_MOVE:
				begin
					nb_bank_q <= home_bank_q;
					nb_row_q  <= home_row_inc;
					nb_col_q  <= home_col_inc;
				end
				sdb_pkg::SDB_BANK:
				begin
					nb_bank_q <= home_bank_inc;
					nb_row_q  <= home_row_q;
					nb_col_q  <= home_col_q;
				end
				default:
				begin
					nb_bank_q <= nb_bank_q;
				end
			endcase
		end
	end

	// disturb repeat counter and its end count
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			cnt_q     <= sdb_pkg::CNT_RST;
			cnt_end_q <= sdb_pkg::CNT_END;
		end
		else if (en_i)
		begin
			if (go)
			begin
				cnt_q     <= sdb_pkg::CNT_RST;
				cnt_end_q <= sdb_pkg::CNT_END;
			end
			else if (state_q == sdb_pkg::SDB_RDCOL
				|| state_q == sdb_pkg::SDB_RDROW)
			begin
				if (cnt_end)
					cnt_q <= sdb_pkg::CNT_RST;
				else
					cnt_q <= cnt_q + sdb_pkg::CNT_W'(1);
			end
		end
	end

	// inner variation and outer inversion passes
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			inner_q <= sdb_pkg::INNER_RST;
			outer_q <= sdb_pkg::OUTER_RST;
		end
		else if (en_i)
		begin
			if (go)
			begin
				inner_q <= sdb_pkg::INNER_RST;
				outer_q <= sdb_pkg::OUTER_RST;
			end
			else
			begin
				if (state_q == sdb_pkg::SDB_RDROW && cnt_end)
					inner_q <= inner_last ? sdb_pkg::INNER_RST
						: inner_q + 2'h1;
				if (state_q == sdb_pkg::SDB_BANK && bank_last)
					outer_q <= sdb_pkg::OUTER_LAST;
			end
		end
	end

	// base pattern, reloaded on every start
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			data_q <= {DATA_W{sdb_pkg::BASE_BIT}};
		else if (en_i && go)
			data_q <= {DATA_W{sdb_pkg::BASE_BIT}};
	end

	// memory command, registered so the pins come straight from flops
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			mem_en_o    <= 1'b0;
			mem_we_o    <= 1'b0;
			mem_addr_o  <= '0;
			mem_wdata_o <= '0;
			exp_q       <= '0;
		end
		else if (en_i)
		begin
			mem_en_o <= 1'b0;
			mem_we_o <= 1'b0;
			case (state_q)
				sdb_pkg::SDB_BKGND:
				begin
					mem_en_o    <= 1'b1;
					mem_we_o    <= 1'b1;
					mem_addr_o  <= {home_bank_q, home_col_q, home_row_q};
					mem_wdata_o <= data_q ^ outer_mask;
				end
				sdb_pkg::SDB_WCOL,
				sdb_pkg::SDB_WROW:
				begin
					mem_en_o    <= 1'b1;
					mem_we_o    <= 1'b1;
					mem_addr_o  <= {nb_bank_q, nb_col_q, nb_row_q};
					mem_wdata_o <= ~data_q ^ outer_mask ^ winv_mask;
				end
				sdb_pkg::SDB_RDCOL,
				sdb_pkg::SDB_RDROW:
				begin
					mem_en_o   <= 1'b1;
					mem_addr_o <= {home_bank_q, home_col_q, home_row_q};
					exp_q      <= data_q ^ outer_mask;
				end
				default:
				begin
					mem_en_o <= 1'b0;
				end
			endcase
		end
	end

	// read data returns one cycle after the memory samples the read
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			chk_q     <= 1'b0;
			chk_exp_q <= '0;
		end
		else if (en_i)
		begin
			chk_q     <= mem_en_o && !mem_we_o;
			chk_exp_q <= exp_q;
		end
	end

	// status; a mismatch in the start cycle still lands
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			fail_o <= 1'b0;
			done_o <= 1'b0;
			busy_o <= 1'b0;
		end
		else if (en_i)
		begin
			fail_o <= (chk_q && mem_rdata_i != chk_exp_q)
				|| (fail_o && !go);
			if (go)
			begin
				done_o <= 1'b0;
				busy_o <= 1'b1;
			end
			else if (state_q == sdb_pkg::SDB_BANK && bank_last
				&& outer_q == sdb_pkg::OUTER_LAST)
			begin
				done_o <= 1'b1;
				busy_o <= 1'b0;
			end
		end
	end

endmodule : sdb_surround_disturb_bist

// ---- sdb_surround_disturb_bist_assertions.sv ----
`timescale 1ns/10ps
module sdb_surround_disturb_bist_chk #(
	parameter int BANK_W = 2,
	parameter int ROW_W  = 4,
	parameter int COL_W  = 4,
	parameter int DATA_W = 8
) (
	input wire logic                          clk_i,       // clock
	input wire logic                          rst_i,       // reset
	input wire logic                          en_i,        // enable
	input wire logic                          start_i,     // start
	input wire logic [DATA_W-1:0]             mem_rdata_i, // read data
	input wire logic                          mem_en_o,    // strobe
	input wire logic                          mem_we_o,    // write
	input wire logic [BANK_W+ROW_W+COL_W-1:0] mem_addr_o,  // address
	input wire logic [DATA_W-1:0]             mem_wdata_o, // write data
	input wire logic                          busy_o,      // running
	input wire logic                          done_o,      // finished
	input wire logic                          fail_o       // mismatch
);
	localparam int AW = BANK_W + ROW_W + COL_W;
	logic             prev_we_q;
	logic [AW-1:0]    prev_addr_q;
	logic [ROW_W-1:0] dr;
	logic [COL_W-1:0] dc;
	logic             rd;
	logic             near;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	assign rd = en_i && mem_en_o && !mem_we_o;
	assign dr = mem_addr_o[ROW_W-1:0] - prev_addr_q[ROW_W-1:0];
	assign dc = mem_addr_o[ROW_W+:COL_W] - prev_addr_q[ROW_W+:COL_W];
	// home read must sit next to the neighbour just written, never on it
	assign near = (mem_addr_o[AW-1:ROW_W+COL_W] == prev_addr_q[AW-1:ROW_W+COL_W])
		&& (dr == '0 || dr == ROW_W'(1) || dr == '1)
		&& (dc == '0 || dc == COL_W'(1) || dc == '1) && (dr != '0 || dc != '0);
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			prev_we_q   <= 1'h0;
			prev_addr_q <= '0;
		end
		else if (en_i && mem_en_o)
		begin
			prev_we_q   <= mem_we_o;
			prev_addr_q <= mem_addr_o;
		end
	end
	sequence s_go;
		start_i && en_i && !busy_o ##1 en_i;
	endsequence
	sequence s_first_wr;
		mem_en_o && mem_we_o && mem_addr_o == '0 && mem_wdata_o == '0;
	endsequence
	a_start_first_write: assert property (s_go |=> s_first_wr)
		else $error("first background write wrong");
	a_start_sets_busy: assert property (start_i && en_i && !busy_o |=> busy_o && !done_o && !fail_o)
		else $error("start not taken");
	a_idle_no_access: assert property (!busy_o |-> !mem_en_o)
		else $error("access while idle");
	a_read_after_write: assert property (rd |-> prev_we_q)
		else $error("read not preceded by write");
	a_read_near_neighbour: assert property (rd |-> near)
		else $error("neighbour not adjacent to home");
	a_wdata_uniform: assert property (en_i && mem_en_o && mem_we_o |-> mem_wdata_o == '0 || mem_wdata_o == '1)
		else $error("write data not a solid pattern");
	a_fail_sticky: assert property (fail_o && !(start_i && en_i && !busy_o) |=> fail_o)
		else $error("fail flag dropped");
	a_done_sticky: assert property (done_o && !(start_i && en_i) |=> done_o)
		else $error("done dropped");
	a_busy_to_done: assert property ($fell(busy_o) |-> done_o && !busy_o)
		else $error("busy ended without done");
endmodule : sdb_surround_disturb_bist_chk

bind sdb_surround_disturb_bist sdb_surround_disturb_bist_chk #(
	.BANK_W(BANK_W), .ROW_W(ROW_W), .COL_W(COL_W), .DATA_W(DATA_W)
) i_chk (
	.clk_i(clk_i), .rst_i(rst_i), .en_i(en_i), .start_i(start_i), .mem_rdata_i(mem_rdata_i),
	.mem_en_o(mem_en_o), .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o),
	.mem_wdata_o(mem_wdata_o), .busy_o(busy_o), .done_o(done_o), .fail_o(fail_o)
);

// ---- sdb_surround_disturb_bist_test.sv ----
`timescale 1ns/10ps
module sdb_surround_disturb_bist_test;
	localparam int BW = 1;
	localparam int RW = 2;
	localparam int CW = 2;
	localparam int DW = 8;
	localparam int AW = BW + RW + CW;
	logic           clk_i = 1'h0;
	logic           rst_i = 1'h1;
	logic           en_i = 1'h1;
	logic           start_i = 1'h0;
	logic           flip = 1'h0;
	logic [16:0]    lfsr = 17'h12b6c;
	logic [DW-1:0]  rdata;
	logic [DW-1:0]  wdata;
	logic [AW-1:0]  addr;
	logic           mem_en;
	logic           mem_we;
	logic           busy;
	logic           done;
	logic           fail;
	logic [AW+DW:0] exp_q[$];
	logic [AW+DW:0] nxt;
	logic [AW+DW:0] seen;
	int             n_mismatch = 0;
	int             n_checks = 0;

	sdb_surround_disturb_bist #(
		.BANK_W(BW), .ROW_W(RW), .COL_W(CW), .DATA_W(DW)
	) i_dut (
		.clk_i(clk_i), .rst_i(rst_i), .en_i(en_i), .start_i(start_i), .mem_rdata_i(rdata),
		.mem_en_o(mem_en), .mem_we_o(mem_we), .mem_addr_o(addr), .mem_wdata_o(wdata),
		.busy_o(busy), .done_o(done), .fail_o(fail)
	);
	sdb_mem_model #(.AW(AW), .DW(DW)) i_mem (
		.clk_i(clk_i), .en_i(en_i), .req_i(mem_en), .we_i(mem_we), .addr_i(addr),
		.wdata_i(wdata), .flip_i(flip), .rdata_o(rdata)
	);

	always #2 clk_i = ~clk_i;

	function automatic logic [16:0] lfsr_next(input logic [16:0] v);
		lfsr_next = {v[15:0], v[16] ^ v[13]};
	endfunction : lfsr_next

	// random stalls stretch some steps
	always @(posedge clk_i)
	begin
		lfsr <= lfsr_next(lfsr);
		en_i <= lfsr[0] | lfsr[1];
	end

	task automatic check(input logic [AW+DW:0] got, input logic [AW+DW:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task automatic stop_test;
		if (n_mismatch == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : stop_test

	task automatic plan_run;
		logic [RW-1:0] nr;
		logic [CW-1:0] nc;
		logic [DW-1:0] wd;
		for (int o = 0; o < 2; o++)
			for (int b = 0; b < 2**BW; b++)
			begin
				for (int h = 0; h < 2**(RW+CW); h++)
					exp_q.push_back({1'h1, BW'(b), (RW+CW)'(h), {DW{o[0]}}});
				for (int h = 0; h < 2**(RW+CW); h++)
				begin
					nr = h[RW-1:0] - 1'h1;
					nc = h[RW+CW-1:RW] - 1'h1;
					for (int p = 0; p < 4; p++)
					begin
						wd = {DW{~(o[0] ^ p[1])}};
						for (int s = 0; s < 4; s++)
						begin
							exp_q.push_back({1'h1, BW'(b), nc, nr, wd});
							if (s < 2)
								nc = p[0] ? nc - 1'h1 : nc + 1'h1;
							else
								nr = p[0] ? nr - 1'h1 : nr + 1'h1;
							exp_q.push_back({1'h0, BW'(b), (RW+CW)'(h), DW'(0)});
						end
					end
				end
			end
	endtask : plan_run

	task automatic run(input logic bad);
		plan_run();
		start_i <= 1'h1;
		for (int i = 0; i < 64; i++)
		begin
			@(posedge clk_i);
			if (en_i)
				break;
		end
		start_i <= 1'h0;
		repeat (300)
			@(posedge clk_i);
		// start held while busy must change nothing
		start_i <= 1'h1;
		flip <= bad;
		repeat (20)
			@(posedge clk_i);
		start_i <= 1'h0;
		flip <= 1'h0;
		for (int i = 0; i < 20000 && done !== 1'h1; i++)
			@(posedge clk_i);
		check({busy, done, fail, exp_q.size() == 0}, {1'h0, 1'h1, bad, 1'h1});
	endtask : run

	always @(posedge clk_i)
		if (!rst_i && en_i && mem_en)
		begin
			nxt = exp_q.size() > 0 ? exp_q.pop_front() : 'x;
			seen = {mem_we, addr, mem_we ? wdata : DW'(0)};
			check(seen, nxt);
		end

	initial
	begin
		repeat (3)
			@(posedge clk_i);
		rst_i <= 1'h0;
		@(posedge clk_i);
		check({busy, done, fail, mem_en}, '0);
		run(1'h0);
		run(1'h1);
		stop_test();
	end
endmodule : sdb_surround_disturb_bist_test
